// ==== core/motor_setpoint_selector.sv ====
// Setpoint selection, display and speed scaling with an AXI4-Lite slave
`timescale 1ns/1ps
`include "motor_setpoint_defines.svh"
module motor_setpoint_selector #(
  parameter int UPDATE_CYCLES = `UPDATE_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Discrete inputs; mode and presets low when shorted to common, key high when held
  input wire logic mode_sel_n_i,
  input wire logic primary_preset_n_i,
  input wire logic secondary_preset_n_i,
  input wire logic set_speed_key_i,
  // Measured frequencies in Hz
  input wire motor_setpoint_pkg::value_t feedback_freq_i,
  input wire motor_setpoint_pkg::value_t ext_ref_freq_i,
  // Display and control outputs
  output motor_setpoint_pkg::value_t display_value_o,
  output logic [1:0] display_dp_o,
  output logic setpoint_shown_o,
  output motor_setpoint_pkg::sp_idx_t active_setpoint_o,
  output logic secondary_mode_o,
  output logic preset_led_o,
  output motor_setpoint_pkg::value_t speed_command_o,
  output motor_setpoint_pkg::value_t tach_value_o
);
  import motor_setpoint_pkg::*;

  logic [2:0] sync_out; // Synchronised mode, preset levels
  logic mode_n_s, pri_pre_n_s, sec_pre_n_s;
  logic [31:0] cfg_reg [`CFG_REGS]; // Writable parameter words
  logic aw_got, w_got, aw_got_nxt, w_got_nxt;
  logic [3:0] aw_idx; // Latched write index
  logic aw_fire, w_fire, wr_fire, b_fire, ar_fire, r_fire;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  sp_idx_t sel_next, active_reg; // Operative setpoint index
  logic sec_mode_reg, preset_reg;
  value_t active_sp; // Value of the operative setpoint
  value_t disp_reg, cmd_reg, tach_reg, rpm_reg;
  logic [1:0] dp_reg;
  logic shown_reg;
  logic [15:0] tick_cnt;
  logic tick;
  calc_state_t state_reg;
  logic scl_start;
  value_t scl_a, scl_b, scl_c, scl_res;
  logic scl_done;

  // Mode and presets cross into the clock domain before use
  level_sync #(.WIDTH(3)) u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .level_i({mode_sel_n_i, primary_preset_n_i, secondary_preset_n_i}),
    .level_o(sync_out)
  );
  assign {mode_n_s, pri_pre_n_s, sec_pre_n_s} = sync_out;

  // Write byte lanes, then keep only implemented field bits
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb, input logic [3:0] idx);
    logic [31:0] m;
    logic [31:0] res;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    res = (old & ~m) | (data & m);
    if (idx >= `REG_PRI_SP_UNITS && idx <= `REG_PRI_DISP_UNITS)
      merge = res & `MASK_UNITS;
    else
      merge = res & `MASK_VALUE;
  endfunction

  // Handshake decode
  assign aw_fire = s_axi_awvalid && awready_reg;
  assign w_fire = s_axi_wvalid && wready_reg;
  assign wr_fire = aw_got && w_got && !bvalid_reg;
  assign b_fire = bvalid_reg && s_axi_bready;
  assign ar_fire = s_axi_arvalid && arready_reg;
  assign r_fire = rvalid_reg && s_axi_rready;
  assign aw_got_nxt = aw_fire || (aw_got && !b_fire);
  assign w_got_nxt = w_fire || (w_got && !b_fire);

  // Address and data are taken in either order, one write in flight
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_idx <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      aw_got <= aw_got_nxt;
      w_got <= w_got_nxt;
      awready_reg <= !aw_got_nxt;
      wready_reg <= !w_got_nxt;
      if (aw_fire)
        aw_idx <= s_axi_awaddr[5:2];
      if (w_fire)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Write response; unmapped or read-only words answer SLVERR
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (aw_idx < 4'(`CFG_REGS)) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (b_fire)
      bvalid_reg <= 1'b0;
  end

  // Parameter store; only a bus write changes it, never the mode pins
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < 4; i++)
        cfg_reg[i] <= `RST_SETPOINT;
      cfg_reg[`REG_PRI_SP_UNITS] <= `RST_PRI_UNITS;
      cfg_reg[`REG_SEC_SP_UNITS] <= `RST_SEC_UNITS;
      cfg_reg[`REG_PRI_DISP_UNITS] <= `RST_PRI_UNITS;
      cfg_reg[`REG_PPR] <= `RST_PPR;
      cfg_reg[`REG_MAX_RPM] <= `RST_MAX_RPM;
    end
    else if (wr_fire && aw_idx < 4'(`CFG_REGS))
      cfg_reg[aw_idx] <= merge(cfg_reg[aw_idx], wdata_reg, wstrb_reg,
        aw_idx);
  end

  // Read channel; answer one cycle after the address is taken
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
    end
    else
    begin
      arready_reg <= !(ar_fire || (rvalid_reg && !r_fire));
      if (ar_fire)
      begin
        rvalid_reg <= 1'b1;
        rresp_reg <= `RESP_OKAY;
        case (s_axi_araddr[5:2])
          `REG_STATUS:
            rdata_reg <= {28'h000_0000, active_reg, sec_mode_reg,
              preset_reg};
          `REG_SPEED_CMD: rdata_reg <= {16'h0000, cmd_reg};
          `REG_TACH: rdata_reg <= {16'h0000, tach_reg};
          `REG_FB_RPM: rdata_reg <= {16'h0000, rpm_reg};
          default:
          begin
            if (s_axi_araddr[5:2] < 4'(`CFG_REGS))
              rdata_reg <= cfg_reg[s_axi_araddr[5:2]];
            else
            begin
              // Unmapped words read zero with an error
              rdata_reg <= 32'h0000_0000;
              rresp_reg <= `RESP_SLVERR;
            end
          end
        endcase
      end
      else if (r_fire)
        rvalid_reg <= 1'b0;
    end
  end

  // Mode pin picks the pair, that mode's preset picks within it
  always_comb
  begin
    if (mode_n_s)
      sel_next = pri_pre_n_s ? 2'h0 : 2'h1;
    else
      sel_next = sec_pre_n_s ? 2'h2 : 2'h3;
  end

  // Selection registered every cycle, so a synchronised pin change acts on the next edge
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      active_reg <= 2'h0;
      sec_mode_reg <= 1'b0;
      preset_reg <= 1'b0;
    end
    else
    begin
      active_reg <= sel_next;
      sec_mode_reg <= !mode_n_s;
      preset_reg <= sel_next[0];
    end
  end

  // Stored values are indexed, so switching modes never rewrites them
  assign active_sp = cfg_reg[active_reg][15:0];

  // Key held: operative setpoint; otherwise the tach reading
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      disp_reg <= 16'h0000;
      dp_reg <= 2'h0;
      shown_reg <= 1'b0;
    end
    else if (set_speed_key_i)
    begin
      disp_reg <= active_sp;
      dp_reg <= active_reg[1] ?
        cfg_reg[`REG_SEC_SP_UNITS][`UNITS_DP_MSB:`UNITS_DP_LSB] :
        cfg_reg[`REG_PRI_SP_UNITS][`UNITS_DP_MSB:`UNITS_DP_LSB];
      shown_reg <= 1'b1;
    end
    else
    begin
      disp_reg <= tach_reg;
      dp_reg <= cfg_reg[`REG_PRI_DISP_UNITS][`UNITS_DP_MSB:`UNITS_DP_LSB];
      shown_reg <= 1'b0;
    end
  end

  // Control update enable; far longer than the three scaler runs
  assign tick = (tick_cnt == 16'(UPDATE_CYCLES - 1));
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  // Shared scaler runs RPM, then command, then tach, per update
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= CALC_IDLE;
      scl_start <= 1'b0;
      scl_a <= 16'h0000;
      scl_b <= 16'h0000;
      scl_c <= 16'h0000;
      rpm_reg <= 16'h0000;
      cmd_reg <= 16'h0000;
      tach_reg <= 16'h0000;
    end
    else
    begin
      scl_start <= 1'b0;
      case (state_reg)
        CALC_IDLE:
        begin
          if (tick)
          begin
            // RPM = Hz * 60 / pulses per revolution
            scl_a <= feedback_freq_i;
            scl_b <= `SEC_PER_MIN;
            scl_c <= cfg_reg[`REG_PPR][15:0];
            scl_start <= 1'b1;
            state_reg <= CALC_RPM;
          end
        end
        CALC_RPM:
        begin
          if (scl_done)
          begin
            rpm_reg <= scl_res;
            scl_a <= active_sp;
            scl_start <= 1'b1;
            if (sec_mode_reg)
            begin
              // Follower: ratio times reference over ratio units
              scl_b <= ext_ref_freq_i;
              scl_c <= cfg_reg[`REG_SEC_SP_UNITS][15:0];
            end
            else
            begin
              // Master: units value maps to maximum feedback RPM
              scl_b <= cfg_reg[`REG_MAX_RPM][15:0];
              scl_c <= cfg_reg[`REG_PRI_SP_UNITS][15:0];
            end
            state_reg <= CALC_CMD;
          end
        end
        CALC_CMD:
        begin
          if (scl_done)
          begin
            cmd_reg <= scl_res;
            scl_a <= rpm_reg;
            scl_b <= cfg_reg[`REG_PRI_DISP_UNITS][15:0];
            scl_c <= cfg_reg[`REG_MAX_RPM][15:0];
            scl_start <= 1'b1;
            state_reg <= CALC_TACH;
          end
        end
        CALC_TACH:
        begin
          if (scl_done)
          begin
            tach_reg <= scl_res;
            state_reg <= CALC_IDLE;
          end
        end
        default: state_reg <= CALC_IDLE;
      endcase
    end
  end

  linear_scaler u_scaler (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .start_i(scl_start),
    .a_i(scl_a),
    .b_i(scl_b),
    .c_i(scl_c),
    .done_o(scl_done),
    .result_o(scl_res)
  );

  // Outputs, all straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign display_value_o = disp_reg;
  assign display_dp_o = dp_reg;
  assign setpoint_shown_o = shown_reg;
  assign active_setpoint_o = active_reg;
  assign secondary_mode_o = sec_mode_reg;
  assign preset_led_o = preset_reg;
  assign speed_command_o = cmd_reg;
  assign tach_value_o = tach_reg;

  // Pins held three cycles pick the documented setpoint
  sequence pins_held_s(logic m, logic p, logic s);
    (mode_sel_n_i == m && primary_preset_n_i == p &&
      secondary_preset_n_i == s) [*3];
  endsequence
  sel_primary_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) pins_held_s(1'b1, 1'b1, 1'b0) |=>
    active_setpoint_o == 2'h0 && !secondary_mode_o)
    else $error("primary without preset must use setpoint one");
  sel_preset_two_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) pins_held_s(1'b1, 1'b0, 1'b0) |=>
    active_setpoint_o == 2'h1 && preset_led_o)
    else $error("primary preset must use setpoint two");
  sel_secondary_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) pins_held_s(1'b0, 1'b0, 1'b1) |=>
    active_setpoint_o == 2'h2 && secondary_mode_o)
    else $error("secondary mode must ignore primary preset");
  sel_preset_four_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) pins_held_s(1'b0, 1'b1, 1'b0) |=>
    active_setpoint_o == 2'h3)
    else $error("secondary preset must use setpoint four");
  mode_latency_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) !$past(sys_rst_i, 1) && !$past(sys_rst_i, 2) &&
    !$past(sys_rst_i, 3) |-> secondary_mode_o == !$past(mode_sel_n_i, 3))
    else $error("mode output does not follow pin in three cycles");
  store_hold_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) (!wr_fire && $changed(mode_n_s)) |=>
    $stable(cfg_reg[0]) && $stable(cfg_reg[2]))
    else $error("mode change altered a stored setpoint");
  key_display_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) set_speed_key_i |=>
    display_value_o == $past(active_sp) && setpoint_shown_o)
    else $error("set speed key did not show operative setpoint");
  dp_source_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) (set_speed_key_i && active_reg[1]) |=>
    display_dp_o == $past(cfg_reg[`REG_SEC_SP_UNITS][17:16]))
    else $error("secondary setpoint shown with wrong decimal point");
  rpm_capture_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) (state_reg == CALC_RPM && scl_done) |=>
    rpm_reg == $past(scl_res) && state_reg == CALC_CMD && scl_start)
    else $error("feedback RPM not captured before command step");
endmodule

// ==== core/motor_setpoint_defines.svh ====
// Offsets, field positions, reset values and timing counts of the selector
`ifndef MOTOR_SETPOINT_DEFINES_SVH
`define MOTOR_SETPOINT_DEFINES_SVH

// Register indices; byte address is index times four
`define REG_SP1 4'h0
`define REG_SP2 4'h1
`define REG_SP3 4'h2
`define REG_SP4 4'h3
`define REG_PRI_SP_UNITS 4'h4
`define REG_SEC_SP_UNITS 4'h5
`define REG_PRI_DISP_UNITS 4'h6
`define REG_PPR 4'h7
`define REG_MAX_RPM 4'h8
`define REG_STATUS 4'h9
`define REG_SPEED_CMD 4'ha
`define REG_TACH 4'hb
`define REG_FB_RPM 4'hc
`define CFG_REGS 9

// Field layout of the units registers: value low, decimal position above
`define UNITS_DP_LSB 16
`define UNITS_DP_MSB 17
`define MASK_VALUE 32'h0000_ffff
`define MASK_UNITS 32'h0003_ffff

// Factory values: RPM scaling, 60 pulses per turn, ratio 1.000
`define RST_SETPOINT 32'h0000_0000
`define RST_PRI_UNITS 32'h0000_07d0
`define RST_SEC_UNITS 32'h0003_03e8
`define RST_PPR 32'h0000_003c
`define RST_MAX_RPM 32'h0000_07d0

// Seconds per minute, for pulse frequency to RPM
`define SEC_PER_MIN 16'h003c

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Control update period
`define UPDATE_TIME_US 100
`define CLK_FREQ_MHZ 100
`define UPDATE_CYCLES (`UPDATE_TIME_US * `CLK_FREQ_MHZ)

// Divider iterations of the scaler
`define DIV_STEPS 6'h20

`endif

// ==== core/motor_setpoint_pkg.sv ====
// Types shared by the setpoint selector files
package motor_setpoint_pkg;
  typedef logic [15:0] value_t;
  typedef logic [1:0] sp_idx_t;
  typedef enum logic [1:0] {CALC_IDLE, CALC_RPM, CALC_CMD, CALC_TACH}
    calc_state_t;
endpackage

// ==== core/level_sync.sv ====
// Two-flop synchroniser for a group of slow level inputs
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] level_i,
  output logic [WIDTH-1:0] level_o
);
  // First stage feeds only the second stage
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Inputs idle high (open switch), so reset to all ones
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
    end
    else
    begin
      meta_reg <= level_i;
      sync_reg <= meta_reg;
    end
  end

  assign level_o = sync_reg;

  // Input reaches the output exactly two edges later
  property sync_delay_p;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (!$past(sys_rst_i, 1) && !$past(sys_rst_i, 2)) |->
        level_o == $past(level_i, 2);
  endproperty
  sync_delay_a: assert property (sync_delay_p)
    else $error("synchroniser delay is not two cycles");
endmodule

// ==== core/linear_scaler.sv ====
// Sequential a*b/c scaler with saturation to 16 bits
`timescale 1ns/1ps
`include "motor_setpoint_defines.svh"
module linear_scaler (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [15:0] a_i,
  input wire logic [15:0] b_i,
  input wire logic [15:0] c_i,
  output logic done_o,
  output logic [15:0] result_o
);
  logic [31:0] quo_reg; // Dividend shifting out, quotient shifting in
  logic [16:0] rem_reg; // Partial remainder
  logic [15:0] div_reg; // Divisor held for the whole run
  logic [5:0] cnt_reg; // Steps left
  logic busy_reg;
  logic done_reg;
  logic [15:0] res_reg;
  logic [16:0] rem_sh;

  // One restoring step: bring down the next dividend bit
  assign rem_sh = {rem_reg[15:0], quo_reg[31]};

  // Start loads the product; a start while busy restarts the run
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      quo_reg <= 32'h0000_0000;
      rem_reg <= 17'h0_0000;
      div_reg <= 16'h0000;
      cnt_reg <= 6'h00;
      busy_reg <= 1'b0;
    end
    else if (start_i)
    begin
      quo_reg <= a_i * b_i;
      rem_reg <= 17'h0_0000;
      div_reg <= c_i;
      cnt_reg <= `DIV_STEPS;
      busy_reg <= 1'b1;
    end
    else if (busy_reg)
    begin
      if (rem_sh >= {1'b0, div_reg})
      begin
        rem_reg <= rem_sh - {1'b0, div_reg};
        quo_reg <= {quo_reg[30:0], 1'b1};
      end
      else
      begin
        rem_reg <= rem_sh;
        quo_reg <= {quo_reg[30:0], 1'b0};
      end
      cnt_reg <= cnt_reg - 6'h01;
      busy_reg <= (cnt_reg != 6'h01);
    end
  end

  // Result and done pulse; zero divisor or overflow saturates
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      done_reg <= 1'b0;
      res_reg <= 16'h0000;
    end
    else
    begin
      done_reg <= busy_reg && !start_i && (cnt_reg == 6'h01);
      if (busy_reg && !start_i && (cnt_reg == 6'h01))
      begin
        if (div_reg == 16'h0000 || quo_reg[30:15] != 16'h0000)
          res_reg <= 16'hffff;
        else
          res_reg <= {quo_reg[14:0], (rem_sh >= {1'b0, div_reg})};
      end
    end
  end

  assign done_o = done_reg;
  assign result_o = res_reg;

  // A lone start finishes thirty-three edges later
  sequence lone_start_s;
    start_i ##1 !start_i [*8];
  endsequence
  property scaler_time_p;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (start_i && !busy_reg) |-> ##33 (done_o || $past(start_i, 1));
  endproperty
  scaler_time_a: assert property (scaler_time_p)
    else $error("scaler did not finish on time");
endmodule

// ==== verification/operator_panel_model.sv ====
// Keypad and mode/preset switch model facing the selector
`timescale 1ns/1ps
module operator_panel_model (
  input wire logic clk_sys_i,
  input wire logic secondary_req_i,
  input wire logic pri_preset_req_i,
  input wire logic sec_preset_req_i,
  input wire logic key_req_i,
  output logic mode_sel_n_o,
  output logic primary_preset_n_o,
  output logic secondary_preset_n_o,
  output logic set_speed_key_o
);
  // Open switches read high at power-up
  initial
  begin
    mode_sel_n_o = 1'h1;
    primary_preset_n_o = 1'h1;
    secondary_preset_n_o = 1'h1;
    set_speed_key_o = 1'h0;
  end

  // A closed switch shorts its pin to common, held while requested
  always @(posedge clk_sys_i)
  begin
    mode_sel_n_o <= ~secondary_req_i;
    primary_preset_n_o <= ~pri_preset_req_i;
    secondary_preset_n_o <= ~sec_preset_req_i;
    set_speed_key_o <= key_req_i;
  end
endmodule

// ==== verification/motor_setpoint_selector_test.sv ====
// Self-checking bench for the setpoint selector
`timescale 1ns/1ps
module motor_setpoint_selector_test;
  import motor_setpoint_pkg::*;
  logic clk_sys_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, setpoint_shown_o, secondary_mode_o, preset_led_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, display_dp_o;
  logic [31:0] s_axi_rdata;
  logic mode_sel_n_i, primary_preset_n_i, secondary_preset_n_i;
  logic set_speed_key_i;
  // Feedback 2000 Hz and reference 500 Hz keep the sums exact
  value_t feedback_freq_i = 16'h07d0, ext_ref_freq_i = 16'h01f4;
  value_t display_value_o, speed_command_o, tach_value_o;
  sp_idx_t active_setpoint_o;
  logic sec_req = 1'h0, pp_req = 1'h0, sp_req = 1'h0, key_req = 1'h0;
  int err_count = 0, total_checks = 0, cycles = 0;
  // Register contents expected after reset, index 0 to 8
  logic [31:0] rst_tab [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h7d0,
    32'h303e8, 32'h7d0, 32'h3c, 32'h7d0};

  initial
    forever #5 clk_sys_i = ~clk_sys_i;

  operator_panel_model panel (.clk_sys_i, .secondary_req_i(sec_req),
    .pri_preset_req_i(pp_req), .sec_preset_req_i(sp_req),
    .key_req_i(key_req), .mode_sel_n_o(mode_sel_n_i),
    .primary_preset_n_o(primary_preset_n_i),
    .secondary_preset_n_o(secondary_preset_n_i),
    .set_speed_key_o(set_speed_key_i));

  // Short update period so a full scaling pass fits in a few hundred cycles
  motor_setpoint_selector #(.UPDATE_CYCLES(200)) dut (.clk_sys_i,
    .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mode_sel_n_i, .primary_preset_n_i,
    .secondary_preset_n_i, .set_speed_key_i, .feedback_freq_i,
    .ext_ref_freq_i, .display_value_o, .display_dp_o, .setpoint_shown_o,
    .active_setpoint_o, .secondary_mode_o, .preset_led_o, .speed_command_o,
    .tach_value_o);

  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  // Address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk_sys_i);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk_sys_i);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic results();
    $display("Checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, well above the thousand or so cycles the tests need
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      results();
    end
  end

  initial
  begin
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [1:0] idx;
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'h0;
    for (int i = 0; i < 9; i++)
    begin
      axi_rd(i * 4, rd, rsp);
      chk("reset value", rst_tab[i], rd);
    end
    // Distinct value in each of the four stores
    for (int i = 0; i < 4; i++)
    begin
      axi_wr(i * 4, 32'h1230 + i, rsp);
      chk("write resp", 32'h0, rsp);
    end
    axi_wr(32'h34, 32'h5a, rsp);
    chk("unmapped bresp", 32'h2, rsp);
    axi_rd(32'h34, rd, rsp);
    chk("unmapped rresp", 32'h2, rsp);
    // Walk every pin combination, then back to plain primary
    key_req <= 1'h1;
    for (int i = 0; i < 9; i++)
    begin
      sec_req <= i[2];
      pp_req <= i[1];
      sp_req <= i[0];
      // Panel flop, two sync stages, selection, then the display flop
      repeat (6) @(posedge clk_sys_i);
      idx = i[2] ? {1'h1, i[0]} : {1'h0, i[1]};
      chk("active", idx, active_setpoint_o);
      chk("secondary", i[2], secondary_mode_o);
      chk("preset led", idx[0], preset_led_o);
      chk("display", 32'h1230 + idx, display_value_o);
      chk("dp", i[2] ? 32'h3 : 32'h0, display_dp_o);
      chk("shown", 32'h1, setpoint_shown_o);
    end
    // Factory scaling: command equals setpoint, tach reads RPM
    repeat (420) @(posedge clk_sys_i);
    chk("master command", 32'h1230, speed_command_o);
    chk("tach", 32'h7d0, tach_value_o);
    key_req <= 1'h0;
    // Panel flop, then the display flop settles after the next edge
    repeat (3) @(posedge clk_sys_i);
    chk("tach shown", 32'h7d0, display_value_o);
    chk("not shown", 32'h0, setpoint_shown_o);
    axi_rd(32'h30, rd, rsp);
    chk("feedback rpm", 32'h7d0, rd);
    // Half the pulses per turn doubles the RPM; follower uses ratio
    axi_wr(32'h1c, 32'h1e, rsp);
    chk("ppr bresp", 32'h0, rsp);
    sec_req <= 1'h1;
    repeat (420) @(posedge clk_sys_i);
    chk("follower command", 32'h919, speed_command_o);
    chk("tach doubled", 32'hfa0, tach_value_o);
    axi_rd(32'h30, rd, rsp);
    chk("rpm doubled", 32'hfa0, rd);
    axi_rd(32'h24, rd, rsp);
    chk("status", 32'ha, rd);
    results();
  end
endmodule
